/* File: rtl/tdt_pkg.sv */
/*
 * Constants and carrier types for the dual 16-bit timer block.
 * Assumes an 8-bit register port from the CPU core and a 25 MHz system clock.
 */
package tdt_pkg;
    // Register addresses on the 8-bit register port
    localparam logic [7:0] TDT_ADDR_CTRL0    = 8'hFA;
    localparam logic [7:0] TDT_ADDR_CTRL1    = 8'hFB;
    localparam logic [7:0] TDT_ADDR_PEND     = 8'hF0;
    localparam logic [7:0] TDT_ADDR_CNT0_H   = 8'hF2;
    localparam logic [7:0] TDT_ADDR_CNT0_L   = 8'hF3;
    localparam logic [7:0] TDT_ADDR_REF0_H   = 8'hF4;
    localparam logic [7:0] TDT_ADDR_REF0_L   = 8'hF5;
    localparam logic [7:0] TDT_ADDR_CNT1_H   = 8'hF6;
    localparam logic [7:0] TDT_ADDR_CNT1_L   = 8'hF7;
    localparam logic [7:0] TDT_ADDR_REF1_H   = 8'hF8;
    localparam logic [7:0] TDT_ADDR_REF1_L   = 8'hF9;
    localparam logic [7:0] TDT_CTRL_RESET    = 8'h00;

    // Control field positions
    localparam int TDT_BIT_OVF_EN   = 0;
    localparam int TDT_BIT_MATCH_EN = 1;
    localparam int TDT_BIT_CLEAR    = 2;
    localparam int TDT_MODE_LO      = 3;
    localparam int TDT_CLK_LO       = 5;

    // Shared pending register bit positions
    localparam int TDT_PEND_OVF0   = 2;
    localparam int TDT_PEND_MATCH0 = 3;
    localparam int TDT_PEND_OVF1   = 4;
    localparam int TDT_PEND_MATCH1 = 5;

    // Clock source codes, bits 7..5
    typedef enum logic [2:0] {
        TDT_CLK_DIV1024 = 3'h0,
        TDT_CLK_DIV256  = 3'h1,
        TDT_CLK_DIV64   = 3'h2,
        TDT_CLK_DIV8    = 3'h3,
        TDT_CLK_DIV1    = 3'h4,
        TDT_CLK_EXT_R   = 3'h5,
        TDT_CLK_EXT_F   = 3'h6,
        TDT_CLK_STOP    = 3'h7
    } tdt_clk_t;

    // Mode codes, bits 4..3
    typedef enum logic [1:0] {
        TDT_MODE_INTERVAL = 2'h0,
        TDT_MODE_CAP_RISE = 2'h1,
        TDT_MODE_CAP_FALL = 2'h2,
        TDT_MODE_PWM      = 2'h3
    } tdt_mode_t;

    // Prescaler ratios
    localparam int TDT_PRE_WIDTH = 10;
    localparam logic [9:0] TDT_PRE_1024 = 10'h3FF;
    localparam logic [9:0] TDT_PRE_256  = 10'h0FF;
    localparam logic [9:0] TDT_PRE_64   = 10'h03F;
    localparam logic [9:0] TDT_PRE_8    = 10'h007;

    // Counter limits
    localparam logic [15:0] TDT_CNT_ZERO = 16'h0000;
    localparam logic [15:0] TDT_CNT_MAX  = 16'hFFFF;

    // Interrupt level and vectors, for the interrupt controller outside
    localparam logic [7:0] TDT_IRQ_LEVEL = 8'h03;
    localparam logic [7:0] TDT_VEC_OVF0  = 8'hDA;
    localparam logic [7:0] TDT_VEC_MAT0  = 8'hD8;
    localparam logic [7:0] TDT_VEC_OVF1  = 8'hDE;
    localparam logic [7:0] TDT_VEC_MAT1  = 8'hDC;

    // Pin group of one instance, all synchronised
    typedef struct packed {
        logic capture_in;
        logic ext_clock_in;
    } tdt_pins_t;

    // Events from one instance
    typedef struct packed {
        logic overflow;
        logic match;
    } tdt_event_t;
endpackage : tdt_pkg

/* File: rtl/tdt_timer.sv */
/*
 * Dual 16-bit timer: interval toggle, PWM and edge capture per instance.
 * Assumes an 8-bit register port (addr, wdata, write and read strobes) from
 * the CPU core, asynchronous pins and an external interrupt controller that
 * pulses a service acknowledge per overflow request.
 *
 * Register map on the port: FA and FB control words, F0 shared pending
 * flags, F2/F3 and F6/F7 counters, F4/F5 and F8/F9 reference registers.
 * The high byte sits at the even address and the low byte at the odd one.
 * Sixteen-bit values are two independent byte writes with no latch, so
 * software reading a running counter may see a torn value.
 * Read data is registered: it stands one cycle after the read strobe.
 * Pending bits clear on a zero write; a one leaves them unchanged.
 * A flag event in the same cycle as its clear keeps the flag set.
 * The prescaler is shared by both instances and never stops, so the
 * first tick after selecting a divider may come early.
 * Pins pass three flip-flops before any edge is taken, which adds
 * three cycles of latency to capture and external clock edges.
 * Interval mode flags an overflow only when the counter leaves all ones
 * without a match; a match at the tick zeroes it instead.
 * The PWM pin is registered and so trails the compare by one cycle.
 * Writing the counter while it runs takes effect at the next edge.
 * Control bit 2 never reads back; it clears the counter and drops.
 * Capture loads the counter as it stood before the edge cycle's tick.
 * Both instances decode the same field layout at their own addresses.
 * Request outputs are levels; the controller outside picks vectors.
 */
`timescale 1ns/100ps
module tdt_timer
    import tdt_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic [1:0] capture_in,
    input  wire logic [1:0] ext_clock_in,
    input  wire logic [1:0] overflow_service_ack,
    output logic      [1:0] timer_out,
    output logic      [1:0] overflow_irq,
    output logic      [1:0] match_irq
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [1:0][7:0]  ctrl_reg, ctrl_next;     // Control registers
    logic [1:0][15:0] cnt_reg, cnt_next;       // Counters
    logic [1:0][15:0] ref_reg, ref_next;       // Reference / capture data
    logic [1:0]       out_reg, out_next;       // Toggle flip-flops
    logic [1:0]       pin_reg, pin_next;       // Shared output pins
    logic [3:0]       pend_reg, pend_next;     // Pending flags, ovf/match per unit
    logic [9:0]       pre_reg, pre_next;       // Common prescaler
    logic [1:0][2:0]  cap_sync, clk_sync;      // Three-stage synchronisers
    logic [1:0][2:0]  cap_sync_next, clk_sync_next;
    logic [1:0]       cap_lvl_reg, cap_lvl_next; // Settled capture level
    logic [1:0]       clk_lvl_reg, clk_lvl_next; // Settled external clock level
    logic [7:0]       rdata_next;
    logic [1:0]       ovf_ev, mat_ev;          // Per-unit events this cycle

    // Prescaler terminal-count test against a ratio mask
    // All ones under the mask marks the last cycle of a period
    function automatic logic pre_hit(input logic [9:0] cnt, input logic [9:0] mask);
        pre_hit = ((cnt & mask) == mask);
    endfunction : pre_hit

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: level changes when stages two and three agree
    always_comb begin
        // Shift each pin into its own three-stage chain
        for (int i = 0; i < 2; i++) begin
            cap_sync_next[i] = {cap_sync[i][1:0], capture_in[i]};
            clk_sync_next[i] = {clk_sync[i][1:0], ext_clock_in[i]};
            // Settled level moves only when stages two and three agree
            cap_lvl_next[i]  = (cap_sync[i][1] == cap_sync[i][2]) ? cap_sync[i][2]
                                                                  : cap_lvl_reg[i];
            clk_lvl_next[i]  = (clk_sync[i][1] == clk_sync[i][2]) ? clk_sync[i][2]
                                                                  : clk_lvl_reg[i];
        end
    end

    // Synchroniser flip-flops and settled levels
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            // Chains reset to the idle low level
            cap_sync    <= '0;
            clk_sync    <= '0;
            cap_lvl_reg <= '0;
            clk_lvl_reg <= '0;
        end else begin
            cap_sync    <= cap_sync_next;
            clk_sync    <= clk_sync_next;
            cap_lvl_reg <= cap_lvl_next;
            clk_lvl_reg <= clk_lvl_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer core and registers, next-state logic
    always_comb begin
        tdt_clk_t  csel;
        tdt_mode_t mode;
        logic      tick;
        logic      cap_edge;
        logic      match;
        logic [7:0] a_ctrl;
        logic [7:0] a_cnt_h, a_cnt_l, a_ref_h, a_ref_l;
        // Loop temporaries start from safe values
        csel     = TDT_CLK_DIV1024;
        mode     = TDT_MODE_INTERVAL;
        tick     = 1'b0;
        cap_edge = 1'b0;
        match    = 1'b0;
        a_ctrl   = 8'h00;
        a_cnt_h  = 8'h00;
        a_cnt_l  = 8'h00;
        a_ref_h  = 8'h00;
        a_ref_l  = 8'h00;
        // Prescaler wraps on its own width
        pre_next  = pre_reg + 10'h001;           // Free-running divider of fxx
        // Every register holds unless a branch below moves it
        ctrl_next = ctrl_reg;
        cnt_next  = cnt_reg;
        ref_next  = ref_reg;
        out_next  = out_reg;
        pin_next  = pin_reg;
        pend_next = pend_reg;
        // No events unless raised by an instance below
        ovf_ev    = '0;
        mat_ev    = '0;
        // Both instances share one body, only addresses differ
        for (int i = 0; i < 2; i++) begin
            // Register addresses of this instance
            a_ctrl  = (i == 0) ? TDT_ADDR_CTRL0  : TDT_ADDR_CTRL1;
            a_cnt_h = (i == 0) ? TDT_ADDR_CNT0_H : TDT_ADDR_CNT1_H;
            a_cnt_l = (i == 0) ? TDT_ADDR_CNT0_L : TDT_ADDR_CNT1_L;
            a_ref_h = (i == 0) ? TDT_ADDR_REF0_H : TDT_ADDR_REF1_H;
            a_ref_l = (i == 0) ? TDT_ADDR_REF0_L : TDT_ADDR_REF1_L;
            // Clock and mode fields of the control word
            csel = tdt_clk_t'(ctrl_reg[i][TDT_CLK_LO +: 3]);
            mode = tdt_mode_t'(ctrl_reg[i][TDT_MODE_LO +: 2]);
            // Count enable from the selected source
            unique case (csel)
                TDT_CLK_DIV1024: tick = pre_hit(pre_reg, TDT_PRE_1024);
                TDT_CLK_DIV256:  tick = pre_hit(pre_reg, TDT_PRE_256);
                TDT_CLK_DIV64:   tick = pre_hit(pre_reg, TDT_PRE_64);
                TDT_CLK_DIV8:    tick = pre_hit(pre_reg, TDT_PRE_8);
                TDT_CLK_DIV1:    tick = 1'b1;
                // External codes count settled pin edges
                TDT_CLK_EXT_R:   tick = clk_lvl_next[i] & ~clk_lvl_reg[i];
                TDT_CLK_EXT_F:   tick = ~clk_lvl_next[i] & clk_lvl_reg[i];
                // Stop code freezes the counter
                TDT_CLK_STOP:    tick = 1'b0;
            endcase
            // Edge of the capture pin, polarity from the mode code
            cap_edge = (mode == TDT_MODE_CAP_RISE) ? (cap_lvl_next[i] & ~cap_lvl_reg[i])
                                                   : (~cap_lvl_next[i] & cap_lvl_reg[i]);
            // Comparator: counter against reference
            match = (cnt_reg[i] == ref_reg[i]);
            // Counter moves only on an enabled tick
            if (tick) begin
                // Interval match: zero, request, toggle
                if (mode == TDT_MODE_INTERVAL && match) begin
                    cnt_next[i] = TDT_CNT_ZERO;
                    mat_ev[i]   = 1'b1;
                    out_next[i] = ~out_reg[i];
                end else begin
                    // Count up; leaving all ones is an overflow
                    cnt_next[i] = cnt_reg[i] + 16'h0001;
                    ovf_ev[i]   = (cnt_reg[i] == TDT_CNT_MAX);
                end
            end
            // Capture load in either capture mode
            if ((mode == TDT_MODE_CAP_RISE || mode == TDT_MODE_CAP_FALL) && cap_edge) begin
                ref_next[i] = cnt_reg[i];
                mat_ev[i]   = 1'b1;
            end
            // Shared pin: PWM compare or toggle flip-flop
            if (mode == TDT_MODE_PWM)
                pin_next[i] = (ref_reg[i] > cnt_reg[i]);
            else
                pin_next[i] = out_reg[i];
            // Register writes
            if (reg_write) begin
                if (reg_addr == a_ctrl) begin
                    ctrl_next[i] = reg_wdata;
                    ctrl_next[i][TDT_BIT_CLEAR] = 1'b0;           // Clear bit self-resets
                    if (reg_wdata[TDT_BIT_CLEAR])
                        cnt_next[i] = TDT_CNT_ZERO;
                end
                // Counter and reference bytes are written apart
                if (reg_addr == a_cnt_h)
                    cnt_next[i][15:8] = reg_wdata;
                if (reg_addr == a_cnt_l)
                    cnt_next[i][7:0] = reg_wdata;
                if (reg_addr == a_ref_h)
                    ref_next[i][15:8] = reg_wdata;
                if (reg_addr == a_ref_l)
                    ref_next[i][7:0] = reg_wdata;
            end
            // Overflow flag: serviced or written zero, event wins
            if (overflow_service_ack[i])
                pend_next[2*i] = 1'b0;
            if (reg_write && reg_addr == TDT_ADDR_PEND && !reg_wdata[TDT_PEND_OVF0 + 2*i])
                pend_next[2*i] = 1'b0;
            // Set last so an event beats a clear
            if (ovf_ev[i])
                pend_next[2*i] = 1'b1;
            // Match flag: only software clears, event wins
            if (reg_write && reg_addr == TDT_ADDR_PEND && !reg_wdata[TDT_PEND_MATCH0 + 2*i])
                pend_next[2*i+1] = 1'b0;
            // Set last here as well
            if (mat_ev[i])
                pend_next[2*i+1] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data mux, registered
    always_comb begin
        // Idle cycles and unmapped addresses read zero
        rdata_next = 8'h00;
        if (reg_read) begin
            // Pending flags sit at bits 5 to 2
            unique case (reg_addr)
                TDT_ADDR_CTRL0:  rdata_next = ctrl_reg[0];
                TDT_ADDR_CTRL1:  rdata_next = ctrl_reg[1];
                TDT_ADDR_PEND:   rdata_next = {2'b00, pend_reg, 2'b00};
                TDT_ADDR_CNT0_H: rdata_next = cnt_reg[0][15:8];
                TDT_ADDR_CNT0_L: rdata_next = cnt_reg[0][7:0];
                TDT_ADDR_REF0_H: rdata_next = ref_reg[0][15:8];
                TDT_ADDR_REF0_L: rdata_next = ref_reg[0][7:0];
                TDT_ADDR_CNT1_H: rdata_next = cnt_reg[1][15:8];
                TDT_ADDR_CNT1_L: rdata_next = cnt_reg[1][7:0];
                TDT_ADDR_REF1_H: rdata_next = ref_reg[1][15:8];
                TDT_ADDR_REF1_L: rdata_next = ref_reg[1][7:0];
                default:         rdata_next = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            // Both instances come up in interval mode, counting on the 1024 prescaler divider
            ctrl_reg  <= {TDT_CTRL_RESET, TDT_CTRL_RESET};
            cnt_reg   <= '0;
            ref_reg   <= '0;
            out_reg   <= '0;
            pin_reg   <= '0;
            pend_reg  <= '0;
            pre_reg   <= '0;
            reg_rdata <= 8'h00;
        end else begin
            // Every flop takes its next value each edge
            ctrl_reg  <= ctrl_next;
            cnt_reg   <= cnt_next;
            ref_reg   <= ref_next;
            out_reg   <= out_next;
            pin_reg   <= pin_next;
            pend_reg  <= pend_next;
            pre_reg   <= pre_next;
            reg_rdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs: pending gated by enables onto level-three requests
    always_comb begin
        // Pin levels come straight from flip-flops
        timer_out = pin_reg;
        // Requests are pending flags masked by enables
        for (int i = 0; i < 2; i++) begin
            overflow_irq[i] = pend_reg[2*i]   & ctrl_reg[i][TDT_BIT_OVF_EN];
            match_irq[i]    = pend_reg[2*i+1] & ctrl_reg[i][TDT_BIT_MATCH_EN];
        end
    end
endmodule : tdt_timer

/* File: dv/tdt_asserts.sv */
/* Port checker for the dual timer: enables, control reads, stop, pending flags.
   Assumes it is bound onto tdt_timer and that read data is registered. */
`timescale 1ns/100ps
module tdt_asserts
    import tdt_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] overflow_service_ack,
    input wire logic [1:0] timer_out,
    input wire logic [1:0] overflow_irq,
    input wire logic [1:0] match_irq
);
    logic [7:0] c0_reg, c0_next, c1_reg, c1_next; // Control shadows
    logic       cw0, cw1, pw, iv0;                // Write decodes, stopped interval
    assign cw0 = reg_write && reg_addr == TDT_ADDR_CTRL0;
    assign cw1 = reg_write && reg_addr == TDT_ADDR_CTRL1;
    assign pw  = reg_write && reg_addr == TDT_ADDR_PEND;
    assign iv0 = c0_reg[7:3] == 5'h1C;
    // Shadow next values; the clear bit is never kept
    always_comb begin
        c0_next = cw0 ? (reg_wdata & 8'hFB) : c0_reg;
        c1_next = cw1 ? (reg_wdata & 8'hFB) : c1_reg;
    end
    // Shadow registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            c0_reg <= TDT_CTRL_RESET;
            c1_reg <= TDT_CTRL_RESET;
        end else begin
            c0_reg <= c0_next;
            c1_reg <= c1_next;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Timer 0 stopped in interval mode for three cycles
    sequence s_still0;
        iv0 [*3];
    endsequence
    property p_ovf_en0; overflow_irq[0] |-> c0_reg[0]; endproperty
    a_ovf_en0: assert property (p_ovf_en0) else $error("overflow request while disabled");
    property p_mat_en0; match_irq[0] |-> c0_reg[1]; endproperty
    a_mat_en0: assert property (p_mat_en0) else $error("match request while disabled");
    property p_en1; (overflow_irq[1] |-> c1_reg[0]) and (match_irq[1] |-> c1_reg[1]); endproperty
    a_en1: assert property (p_en1) else $error("timer 1 request while disabled");
    property p_ctrl0_rd;
        reg_read && !reg_write && reg_addr == TDT_ADDR_CTRL0 |=> reg_rdata == $past(c0_reg);
    endproperty
    a_ctrl0_rd: assert property (p_ctrl0_rd) else $error("control 0 read wrong");
    property p_ctrl1_rd;
        reg_read && !reg_write && reg_addr == TDT_ADDR_CTRL1 |=> reg_rdata == $past(c1_reg);
    endproperty
    a_ctrl1_rd: assert property (p_ctrl1_rd) else $error("control 1 read wrong");
    property p_stop0; s_still0 |=> $stable(timer_out[0]); endproperty
    a_stop0: assert property (p_stop0) else $error("stopped timer moved its pin");
    property p_ack0; s_still0 ##0 overflow_service_ack[0] |=> !overflow_irq[0]; endproperty
    a_ack0: assert property (p_ack0) else $error("service left overflow pending");
    property p_hold0; match_irq[0] && !pw && !cw0 |=> match_irq[0]; endproperty
    a_hold0: assert property (p_hold0) else $error("match 0 pending dropped");
    property p_hold1; match_irq[1] && !pw && !cw1 |=> match_irq[1]; endproperty
    a_hold1: assert property (p_hold1) else $error("match 1 pending dropped");
endmodule : tdt_asserts
bind tdt_timer tdt_asserts tdt_asserts_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .overflow_service_ack(overflow_service_ack),
    .timer_out(timer_out), .overflow_irq(overflow_irq), .match_irq(match_irq));

/* File: dv/tdt_pin_model.sv */
/* Pin-side model: capture and external clock pins of both timers.
   Assumes the bench steers capture levels and clock bursts. */
`timescale 1ns/100ps
module tdt_pin_model (
    input  wire logic       ref_clk,
    input  wire logic [1:0] cap_level,
    input  wire logic [1:0] ext_run,
    output logic      [1:0] capture_in,
    output logic      [1:0] ext_clock_in
);
    logic [1:0] ph [2]; // Phase counters
    // Capture pins follow the bench, port routing taken as set
    assign capture_in = cap_level;
    // External clock toggles every 4 cycles, rests low between bursts
    always @(negedge ref_clk) begin
        for (int i = 0; i < 2; i++) begin
            ph[i] <= ext_run[i] ? ph[i] + 2'h1 : 2'h0;
            if (!ext_run[i])
                ext_clock_in[i] <= 1'b0;
            else if (ph[i] == 2'h3)
                ext_clock_in[i] <= !ext_clock_in[i];
        end
    end
endmodule : tdt_pin_model

/* File: dv/tb_dual_16bit_timer_interval_pwm_capture.sv */
/* Self-checking bench for the dual timer with random values.
   Assumes tdt_timer, its bound checker and the pin model. */
`timescale 1ns/100ps
module tb_dual_16bit_timer_interval_pwm_capture
    import tdt_pkg::*;
;
    logic        ref_clk, reset_n, reg_write, reg_read;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
    logic [1:0]  ack, timer_out, overflow_irq, match_irq, cap_level, ext_run, cap, ext;
    logic [31:0] seed = 32'hF8F4;
    logic [15:0] rw, v;
    int          n_mismatch, compares, cycles, k, n;
    logic [7:0]  ra [3] = '{TDT_ADDR_CTRL0, TDT_ADDR_CTRL1, TDT_ADDR_PEND};
    tdt_timer tdt_timer_i (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .capture_in(cap), .ext_clock_in(ext),
        .overflow_service_ack(ack), .timer_out(timer_out), .overflow_irq(overflow_irq),
        .match_irq(match_irq));
    tdt_pin_model tdt_pin_model_i (.ref_clk(ref_clk), .cap_level(cap_level),
        .ext_run(ext_run), .capture_in(cap), .ext_clock_in(ext));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Expected ticks for a divider code over a span of cycles
    function automatic int ticks(input int code, input int span);
        int sh [5] = '{10, 8, 6, 3, 0};
        return span >> sh[code];
    endfunction : ticks
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] val);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = val;
        reg_write = 1'b1;
        @(negedge ref_clk);
        reg_write = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge ref_clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge ref_clk);
        reg_read = 1'b0;
        d = reg_rdata;
    endtask : rd
    task automatic w16(input logic [7:0] a, input logic [15:0] val);
        wr(a, val[15:8]);
        wr(8'(a + 8'h01), val[7:0]);
    endtask : w16
    task automatic r16(input logic [7:0] a);
        rd(a);
        rw[15:8] = d;
        rd(8'(a + 8'h01));
        rw[7:0] = d;
    endtask : r16
    // Cycles until the timer 0 pin changes
    task automatic gap();
        logic w;
        w = timer_out[0];
        k = 0;
        while (timer_out[0] === w && k < 300) begin
            @(negedge ref_clk);
            k++;
        end
    endtask : gap
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        {reset_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
        {ack, cap_level, ext_run} = '0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        reset_n = 1'b1;
        for (int i = 0; i < 3; i++) begin
            rd(ra[i]);
            chk("reset read", d, 16'h0000);
        end
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            wr(ra[i % 2], seed[7:0]);
            rd(ra[i % 2]);
            chk("control", d, seed[7:0] & 8'hFB);
        end
        wr(TDT_ADDR_CTRL0, 8'hE0);
        wr(TDT_ADDR_CTRL1, 8'hE0);
        wr(TDT_ADDR_PEND, 8'h00);
        $display("control test done");
        seed = xs(seed);
        w16(TDT_ADDR_CNT0_H, seed[15:0]);
        repeat (20) @(negedge ref_clk);
        r16(TDT_ADDR_CNT0_H);
        chk("stopped count", rw, seed[15:0]);
        wr(TDT_ADDR_CTRL0, 8'hE4);
        r16(TDT_ADDR_CNT0_H);
        chk("cleared count", rw, 16'h0000);
        $display("stop and clear test done");
        wr(TDT_ADDR_CTRL0, 8'hF8);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            v = (i == 0) ? seed[31:16] : (i == 1) ? seed[31:16] + 16'h0001 : seed[15:0];
            w16(TDT_ADDR_REF0_H, v);
            w16(TDT_ADDR_CNT0_H, seed[31:16]);
            repeat (3) @(negedge ref_clk);
            chk("pwm level", timer_out[0], v > seed[31:16]);
        end
        w16(TDT_ADDR_CNT0_H, 16'hFFFE);
        wr(TDT_ADDR_CTRL0, 8'h98);
        wr(TDT_ADDR_CTRL0, 8'hF8);
        r16(TDT_ADDR_CNT0_H);
        chk("wrapped", rw < 16'h0010, 1'b1);
        chk("ovf masked", overflow_irq[0], 1'b0);
        rd(TDT_ADDR_PEND);
        chk("ovf pending", d[2], 1'b1);
        wr(TDT_ADDR_CTRL0, 8'hE1);
        chk("ovf request", overflow_irq[0], 1'b1);
        repeat (3) @(negedge ref_clk);
        ack = 2'h3;
        @(negedge ref_clk);
        ack = 2'h0;
        chk("ovf serviced", overflow_irq[0], 1'b0);
        $display("pwm test done");
        seed = xs(seed);
        n = 4 + int'(seed[3:0]);
        w16(TDT_ADDR_REF0_H, 16'(n));
        wr(TDT_ADDR_CTRL0, 8'h86);
        gap();
        gap();
        chk("half period", 16'(k), 16'(n + 1));
        chk("match request", match_irq[0], 1'b1);
        wr(TDT_ADDR_CTRL0, 8'hE2);
        rd(TDT_ADDR_PEND);
        chk("match pending", d[3], 1'b1);
        wr(TDT_ADDR_PEND, 8'h00);
        chk("match cleared", match_irq[0], 1'b0);
        $display("interval test done");
        w16(TDT_ADDR_REF0_H, 16'hFFFF);
        for (int c = 0; c < 7; c++) begin
            w16(TDT_ADDR_CNT0_H, 16'h0000);
            wr(TDT_ADDR_CTRL0, {3'(c), 5'h00});
            if (c < 5) begin
                repeat (2048) @(negedge ref_clk);
            end else begin
                ext_run <= 2'h3;
                repeat (40) @(negedge ref_clk);
                ext_run <= 2'h0;
                repeat (8) @(negedge ref_clk);
            end
            wr(TDT_ADDR_CTRL0, 8'hE0);
            r16(TDT_ADDR_CNT0_H);
            n = (c < 5) ? ticks(c, 2048) : 5;
            chk("ticks", int'(rw) + 3 >= n && int'(rw) <= n + 3, 1'b1);
        end
        $display("clock source test done");
        for (int j = 0; j < 2; j++) begin
            for (int e = 0; e < 2; e++) begin
                wr(TDT_ADDR_PEND, 8'h00);
                wr(8'(TDT_ADDR_CTRL0 + j), e ? 8'hF2 : 8'hEA);
                seed = xs(seed);
                w16(8'(TDT_ADDR_CNT0_H + 4 * j), seed[15:0]);
                cap_level[j] = !e;
                repeat (8) @(negedge ref_clk);
                r16(8'(TDT_ADDR_REF0_H + 4 * j));
                chk("captured", rw, seed[15:0]);
                chk("capture request", match_irq[j], 1'b1);
            end
        end
        $display("capture test done");
        wr(TDT_ADDR_CTRL1, 8'hF8);
        seed = xs(seed);
        w16(TDT_ADDR_REF1_H, seed[31:16]);
        w16(TDT_ADDR_CNT1_H, seed[15:0]);
        repeat (3) @(negedge ref_clk);
        chk("pwm level 1", timer_out[1], seed[31:16] > seed[15:0]);
        w16(TDT_ADDR_CNT1_H, 16'hFFFF);
        wr(TDT_ADDR_CTRL1, 8'h89);
        wr(TDT_ADDR_CTRL1, 8'hE9);
        chk("capture overflow", overflow_irq[1], 1'b1);
        ack = 2'h2;
        @(negedge ref_clk);
        ack = 2'h0;
        chk("ovf 1 serviced", overflow_irq[1], 1'b0);
        $display("timer 1 test done");
        report_and_stop();
    end
endmodule : tb_dual_16bit_timer_interval_pwm_capture
